/* File: power_mode_consts.svh */
// named constants of the power mode manager: offsets, fields, timings
// assumes inclusion by bare name from the package and the design files
`ifndef POWER_MODE_CONSTS_SVH
`define POWER_MODE_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_PORT_ONE_PWR 8'h1d
`define OFS_PORT_TWO_PWR 8'h2d
`define OFS_GLOBAL_MODE 8'hc3
`define OFS_IDLE_SLEEP 8'hc4
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define MODE_HI 5
`define MODE_LO 4
`define PORT_PD_BIT 3
`define REG_RESET 8'h00
`define CODE_NORMAL 2'b00
`define CODE_EDETECT 2'b01
`define CODE_SOFTPD 2'b10
`define CODE_SAVING 2'b11
// ----------------------------------------
// timing: clock 125 MHz, pulse 120 ns, pulse period 1 s
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define PULSE_WIDTH_NS 120
`define PULSE_CYCLES ((`PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_PERIOD_NS 1000000000
`define PULSE_PERIOD_CYC (`PULSE_PERIOD_NS / `CLK_PERIOD_NS)
// one go-sleep unit, in cycles; default is 1 ms per unit
`define SLEEP_UNIT_CYC 125000
`endif

/* File: power_mode_pkg.sv */
// types of the power mode manager
// assumes the constants header is in the include path
`include "power_mode_consts.svh"
package power_mode_pkg;
	// ----------------------------------------
	// power sequencing states, one-hot
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_NORMAL = 6'h01, // full power
		ST_ED_AWAKE = 6'h02, // energy detect, normal power state
		ST_ED_SLEEP = 6'h04, // energy detect, low power state
		ST_SOFT_PD = 6'h08, // soft power down
		ST_SAVING = 6'h10, // power saving, receiver block off
		ST_HW_PD = 6'h20 // chip power-down pin asserted
	} pwr_state_t;
endpackage

/* File: sleep_pulse_gen.sv */
// periodic line pulse generator for the energy detect low power state
// assumes core_clk at 125 MHz and a same-domain enable
`timescale 1ns/1ns
`default_nettype none
`include "power_mode_consts.svh"
module sleep_pulse_gen #(
	parameter int unsigned PERIOD_CYC = `PULSE_PERIOD_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic enable,
	output logic pulse
);
	import power_mode_pkg::*;
	// ----------------------------------------
	// period and width counters
	// ----------------------------------------
	logic [26:0] per_q, per_d; // position within the period
	logic pulse_q, pulse_d; // registered line pulse
	// next-value logic; a pulse opens each period
	always_comb begin
		per_d = per_q;
		pulse_d = 1'b0;
		if (!enable) begin
			per_d = '0;
		end else begin
			if (per_q == 27'(PERIOD_CYC - 1)) begin
				per_d = '0;
			end else begin
				per_d = per_q + 27'd1;
			end
			pulse_d = (per_q < 27'(`PULSE_CYCLES));
		end
	end
	// registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			per_q <= '0;
			pulse_q <= 1'b0;
		end else begin
			per_q <= per_d;
			pulse_q <= pulse_d;
		end
	end
	assign pulse = pulse_q;
	// pulse is exactly the rounded-up width, 15 cycles; a wake may cut it
	AST_PULSE_WIDTH: assert property (@(posedge core_clk)
		disable iff (srst || !enable)
		$rose(pulse) |-> pulse [*8] ##1 pulse [*7] ##1 !pulse)
		else $error("line pulse width wrong");
endmodule
`default_nettype wire

/* File: power_mode_manager.sv */
// power mode manager: global modes, per-port power down, energy detect
// assumes a same-clock register port; pin inputs arrive asynchronously
`timescale 1ns/1ns
`default_nettype none
`include "power_mode_consts.svh"
module power_mode_manager #(
	parameter int unsigned SLEEP_UNIT = `SLEEP_UNIT_CYC,
	parameter int unsigned PULSE_PERIOD = `PULSE_PERIOD_CYC
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic chip_power_down_n,
	input wire logic reg_access,
	input wire logic reg_write,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic cable_energy,
	input wire logic autoneg_enable,
	input wire logic cable_connected,
	output logic pll_clk_enable,
	output logic [1:0] phy_tx_enable,
	output logic [1:0] phy_rx_enable,
	output logic energy_detect_enable,
	output logic mac_enable,
	output logic host_if_enable,
	output logic packet_enable,
	output logic line_pulse,
	output var power_mode_pkg::pwr_state_t power_state
);
	import power_mode_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] sync1_q, sync2_q; // two stages for the four pins
	// first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync1_q <= 4'hf;
			sync2_q <= 4'hf;
		end else begin
			sync1_q <= {chip_power_down_n, cable_energy, autoneg_enable,
				cable_connected};
			sync2_q <= sync1_q;
		end
	end
	wire pd_n_s = sync2_q[3]; // synchronised pin levels
	wire energy_s = sync2_q[2];
	wire an_s = sync2_q[1];
	wire cable_s = sync2_q[0];
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] port1_q, port1_d; // port one power control
	logic [7:0] port2_q, port2_d; // port two power control
	logic [7:0] gmode_q, gmode_d; // global power mode
	logic [7:0] sleep_q, sleep_d; // idle sleep delay
	logic [7:0] rdata_q, rdata_d; // read data
	logic wr_ok; // writes take effect
	logic woke; // host access wakes soft down
	pwr_state_t st_q, st_d; // power state
	// writes are lost while the pin holds the chip down or in soft power down
	assign wr_ok = reg_access && reg_write && st_q != ST_HW_PD
		&& st_q != ST_SOFT_PD;
	assign woke = reg_access && st_q == ST_SOFT_PD;
	// register next values
	always_comb begin
		port1_d = port1_q;
		port2_d = port2_q;
		gmode_d = gmode_q;
		sleep_d = sleep_q;
		rdata_d = rdata_q;
		if (woke) begin
			// wake access only clears the mode code, values kept
			gmode_d[`MODE_HI:`MODE_LO] = `CODE_NORMAL;
		end else if (wr_ok) begin
			unique case (reg_addr)
				`OFS_PORT_ONE_PWR: port1_d = reg_wdata;
				`OFS_PORT_TWO_PWR: port2_d = reg_wdata;
				`OFS_GLOBAL_MODE: gmode_d = reg_wdata;
				`OFS_IDLE_SLEEP: sleep_d = reg_wdata;
				default: ; // unmapped, ignored
			endcase
		end
		if (reg_access && !reg_write && st_q != ST_HW_PD
			&& st_q != ST_SOFT_PD) begin
			unique case (reg_addr)
				`OFS_PORT_ONE_PWR: rdata_d = port1_q;
				`OFS_PORT_TWO_PWR: rdata_d = port2_q;
				`OFS_GLOBAL_MODE: rdata_d = gmode_q;
				`OFS_IDLE_SLEEP: rdata_d = sleep_q;
				default: rdata_d = 8'h00; // unmapped reads zero
			endcase
		end
	end
	// register storage; soft down leaves contents untouched except the mode code that the wake access clears
	always_ff @(posedge core_clk) begin
		if (srst) begin
			port1_q <= `REG_RESET;
			port2_q <= `REG_RESET;
			gmode_q <= `REG_RESET;
			sleep_q <= `REG_RESET;
			rdata_q <= 8'h00;
		end else begin
			port1_q <= port1_d;
			port2_q <= port2_d;
			gmode_q <= gmode_d;
			sleep_q <= sleep_d;
			rdata_q <= rdata_d;
		end
	end
	assign reg_rdata = rdata_q;
	// ----------------------------------------
	// go-sleep timer
	// ----------------------------------------
	logic [16:0] unit_q, unit_d; // cycles within one time unit
	logic [8:0] idle_q, idle_d; // idle units seen
	logic idle_expired; // quiet longer than the go-sleep value
	// counts only while awake in energy detect with a quiet cable
	always_comb begin
		unit_d = '0;
		idle_d = '0;
		if (st_q == ST_ED_AWAKE && !energy_s) begin
			unit_d = unit_q + 17'd1;
			idle_d = idle_q;
			if (unit_q == 17'(SLEEP_UNIT - 1)) begin
				unit_d = '0;
				if (!idle_d[8]) begin
					idle_d = idle_q + 9'd1;
				end
			end
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			unit_q <= '0;
			idle_q <= '0;
		end else begin
			unit_q <= unit_d;
			idle_q <= idle_d;
		end
	end
	// strictly longer than the programmed time
	assign idle_expired = idle_q > {1'b0, sleep_q};
	// ----------------------------------------
	// power state machine
	// ----------------------------------------
	wire [1:0] code = gmode_q[`MODE_HI:`MODE_LO]; // selected global mode
	// next state; pin power-down overrides every mode
	always_comb begin
		st_d = st_q;
		if (!pd_n_s) begin
			st_d = ST_HW_PD;
		end else begin
			unique case (st_q)
				ST_HW_PD: st_d = ST_NORMAL;
				ST_SOFT_PD: begin
					if (woke) begin
						st_d = ST_NORMAL;
					end
				end
				ST_ED_SLEEP: begin
					if (code != `CODE_EDETECT) begin
						st_d = ST_NORMAL;
					end else if (energy_s) begin
						st_d = ST_ED_AWAKE;
					end
				end
				ST_ED_AWAKE: begin
					if (code != `CODE_EDETECT) begin
						st_d = ST_NORMAL;
					end else if (idle_expired) begin
						st_d = ST_ED_SLEEP;
					end
				end
				ST_SAVING: begin
					// line activity or a new code ends saving
					if (code != `CODE_SAVING || !an_s || cable_s
						|| energy_s) begin
						st_d = ST_NORMAL;
					end
				end
				ST_NORMAL: begin
					unique case (code)
						`CODE_EDETECT: st_d = ST_ED_AWAKE;
						`CODE_SOFTPD: st_d = ST_SOFT_PD;
						`CODE_SAVING: begin
							if (an_s && !cable_s && !energy_s) begin
								st_d = ST_SAVING;
							end
						end
						default: st_d = ST_NORMAL;
					endcase
				end
				default: st_d = ST_NORMAL;
			endcase
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_q <= ST_NORMAL;
		end else begin
			st_q <= st_d;
		end
	end
	// ----------------------------------------
	// block enables, registered
	// ----------------------------------------
	logic pll_q, pll_d, mac_q, mac_d, host_q, host_d, ed_q, ed_d, pkt_q, pkt_d;
	logic [1:0] tx_q, tx_d, rx_q, rx_d; // per-port PHY enables
	wire [1:0] port_pd = {port2_q[`PORT_PD_BIT], port1_q[`PORT_PD_BIT]};
	// enables follow the next state so they change with it
	always_comb begin
		pll_d = 1'b1;
		mac_d = 1'b1;
		host_d = 1'b1;
		ed_d = 1'b0;
		tx_d = 2'b11;
		rx_d = 2'b11;
		pkt_d = 1'b1;
		unique case (st_d)
			ST_HW_PD: begin
				pll_d = 1'b0;
				mac_d = 1'b0;
				host_d = 1'b0;
				tx_d = 2'b00;
				rx_d = 2'b00;
				pkt_d = 1'b0;
			end
			ST_SOFT_PD: begin
				pll_d = 1'b0;
				mac_d = 1'b0;
				tx_d = 2'b00;
				rx_d = 2'b00;
				pkt_d = 1'b0;
			end
			ST_ED_SLEEP: begin
				pll_d = 1'b0;
				mac_d = 1'b0;
				host_d = 1'b0;
				tx_d = 2'b00;
				rx_d = 2'b00;
				ed_d = 1'b1;
				pkt_d = 1'b0;
			end
			ST_SAVING: begin
				rx_d = 2'b00;
				ed_d = 1'b1;
			end
			default: ;
		endcase
		tx_d = tx_d & ~port_pd;
		rx_d = rx_d & ~port_pd;
	end
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pll_q <= 1'b1;
			mac_q <= 1'b1;
			host_q <= 1'b1;
			ed_q <= 1'b0;
			pkt_q <= 1'b1;
			tx_q <= 2'b11;
			rx_q <= 2'b11;
		end else begin
			pll_q <= pll_d;
			mac_q <= mac_d;
			host_q <= host_d;
			ed_q <= ed_d;
			pkt_q <= pkt_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
		end
	end
	assign pll_clk_enable = pll_q;
	assign mac_enable = mac_q;
	assign host_if_enable = host_q;
	assign energy_detect_enable = ed_q;
	assign packet_enable = pkt_q;
	assign phy_tx_enable = tx_q;
	assign phy_rx_enable = rx_q;
	assign power_state = st_q;
	// ----------------------------------------
	// sleep pulse generator
	// ----------------------------------------
	sleep_pulse_gen #(.PERIOD_CYC(PULSE_PERIOD)) u_pulse (
		.core_clk(core_clk),
		.srst(srst),
		.enable(st_q == ST_ED_SLEEP),
		.pulse(line_pulse) // registered in the generator
	);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_PIN_DOWN: assert property (!pd_n_s |=> st_q == ST_HW_PD
		&& !pll_clk_enable) else $error("pin power-down not honoured");
	AST_PORT_DOWN: assert property (port1_q[`PORT_PD_BIT]
		|=> !phy_tx_enable[0]) else $error("port one PHY not down");
	AST_SLEEP_SILENT: assert property (st_q == ST_ED_SLEEP
		|-> !packet_enable && energy_detect_enable)
		else $error("packets allowed in low power");
	AST_WAKE_ED: assert property (st_q == ST_ED_SLEEP && energy_s
		&& pd_n_s && code == `CODE_EDETECT |=> st_q == ST_ED_AWAKE)
		else $error("no wake on energy");
	AST_SOFT_WAKE: assert property (woke && pd_n_s
		|=> st_q == ST_NORMAL && code == `CODE_NORMAL)
		else $error("host access did not wake");
	AST_SOFT_OFF: assert property (st_q == ST_SOFT_PD
		|-> !pll_clk_enable && !mac_enable)
		else $error("clocks on in soft power down");
	AST_SAVE_RX: assert property (st_q == ST_SAVING
		|-> phy_rx_enable == 2'b00 && pll_clk_enable)
		else $error("saving enables wrong");
	AST_SAVE_ENTRY: assert property ($rose(st_q == ST_SAVING)
		|-> $past(an_s) && !$past(cable_s))
		else $error("saving entered illegally");
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the power mode manager, register port driven
// assumes the constants header and the design package compile first
`timescale 1ns/1ns
`default_nettype none
`include "power_mode_consts.svh"
module tb;
	import power_mode_pkg::*;
	// ----------------------------------------
	// stimulus, results, counters
	// ----------------------------------------
	logic core_clk = 1'b0; // 125 MHz
	logic srst = 1'b1; // held 2 cycles
	logic chip_power_down_n = 1'b1; // pin idle
	logic reg_access = 1'b0;
	logic reg_write = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic cable_energy = 1'b0;
	logic autoneg_enable = 1'b0;
	logic cable_connected = 1'b1;
	logic [7:0] reg_rdata;
	logic pll_clk_enable, energy_detect_enable, mac_enable;
	logic host_if_enable, packet_enable, line_pulse;
	logic [1:0] phy_tx_enable, phy_rx_enable;
	pwr_state_t power_state;
	logic [8:0] en_vec; // all enables, for masked compares
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	int w, g;
	assign en_vec = {pll_clk_enable, mac_enable, host_if_enable,
		energy_detect_enable, packet_enable, phy_tx_enable, phy_rx_enable};
	// short counts so sleep and pulse fit a quick run
	power_mode_manager #(.SLEEP_UNIT(4), .PULSE_PERIOD(40)) DUT (
		.core_clk(core_clk), .srst(srst),
		.chip_power_down_n(chip_power_down_n), .reg_access(reg_access),
		.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .cable_energy(cable_energy),
		.autoneg_enable(autoneg_enable), .cable_connected(cable_connected),
		.pll_clk_enable(pll_clk_enable), .phy_tx_enable(phy_tx_enable),
		.phy_rx_enable(phy_rx_enable),
		.energy_detect_enable(energy_detect_enable),
		.mac_enable(mac_enable), .host_if_enable(host_if_enable),
		.packet_enable(packet_enable), .line_pulse(line_pulse),
		.power_state(power_state));
	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	always #4 core_clk = ~core_clk;
	// tests need under a thousand cycles; a hang is cut well after
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			final_report();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask
	// masked compare of the enable outputs
	task automatic ens(input logic [8:0] m, input logic [8:0] e,
		input string what);
		chk({7'h00, en_vec & m}, {7'h00, e}, what);
	endtask
	// one-cycle access; strobe drops on the next edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_access <= 1'b1;
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_access <= 1'b0;
		reg_write <= 1'b0;
	endtask
	// read data is sampled a full cycle after the access is taken
	task automatic rdc(input logic [7:0] a, input logic [7:0] e,
		input string what);
		@(posedge core_clk);
		reg_access <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_access <= 1'b0;
		@(posedge core_clk);
		#1;
		chk({8'h00, reg_rdata}, {8'h00, e}, what);
	endtask
	// bounded wait for a state, then compare it
	task automatic wait_state(input pwr_state_t st, input int lim,
		input string what);
		int i;
		#1;
		for (i = 0; i < lim && power_state !== st; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk({10'h000, power_state}, {10'h000, st}, what);
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		repeat (3) @(posedge core_clk);
		// reset values
		wait_state(ST_NORMAL, 1, "reset state");
		ens(9'h1ff, 9'h1df, "reset enables");
		rdc(`OFS_GLOBAL_MODE, `REG_RESET, "mode reset");
		rdc(`OFS_IDLE_SLEEP, `REG_RESET, "sleep reset");
		rdc(`OFS_PORT_TWO_PWR, `REG_RESET, "port two reset");
		$display("test reset done");
		// registers and unmapped place
		wr(`OFS_IDLE_SLEEP, 8'ha5);
		rdc(`OFS_IDLE_SLEEP, 8'ha5, "sleep rw");
		wr(8'h77, 8'hff);
		rdc(8'h77, 8'h00, "unmapped");
		wr(`OFS_PORT_ONE_PWR, 8'h08);
		// enables register from the stored bit one edge after the write
		@(posedge core_clk);
		wait_state(ST_NORMAL, 1, "port down state");
		ens(9'h00f, 9'h00a, "port one down");
		$display("test registers done");
		// power saving with port one kept down
		@(posedge core_clk) autoneg_enable <= 1'b1;
		cable_connected <= 1'b0;
		wr(`OFS_GLOBAL_MODE, 8'h30);
		wait_state(ST_SAVING, 8, "saving entry");
		ens(9'h1ef, 9'h1e8, "saving enables");
		@(posedge core_clk) cable_energy <= 1'b1;
		wait_state(ST_NORMAL, 8, "saving exit");
		wr(`OFS_GLOBAL_MODE, 8'h00);
		cable_energy <= 1'b0;
		wr(`OFS_PORT_ONE_PWR, 8'h00);
		$display("test saving done");
		// energy detect: idle timer, sleep, pulses, wake
		wr(`OFS_IDLE_SLEEP, 8'h02);
		wr(`OFS_GLOBAL_MODE, 8'h10);
		repeat (2) @(posedge core_clk);
		wait_state(ST_ED_AWAKE, 1, "awake first");
		ens(9'h010, 9'h010, "awake packets");
		wait_state(ST_ED_SLEEP, 80, "sleep entry");
		ens(9'h1f0, 9'h020, "sleep enables");
		for (w = 0; w < 50 && line_pulse !== 1'b1; w++) @(posedge core_clk) #1;
		for (w = 0; w < 50 && line_pulse === 1'b1; w++) @(posedge core_clk) #1;
		chk(16'(w), 16'd15, "pulse width");
		for (g = w; g < 99 && line_pulse !== 1'b1; g++) @(posedge core_clk) #1;
		chk(16'(g), 16'd40, "pulse period");
		@(posedge core_clk) cable_energy <= 1'b1;
		wait_state(ST_ED_AWAKE, 8, "energy wake");
		wr(`OFS_GLOBAL_MODE, 8'h00);
		wait_state(ST_NORMAL, 8, "detect exit");
		cable_energy <= 1'b0;
		$display("test energy detect done");
		// soft power down and wake by a dummy access
		wr(`OFS_GLOBAL_MODE, 8'h25);
		wait_state(ST_SOFT_PD, 4, "soft entry");
		ens(9'h18f, 9'h000, "soft enables");
		wr(`OFS_IDLE_SLEEP, 8'h33);
		wait_state(ST_NORMAL, 6, "soft wake");
		rdc(`OFS_GLOBAL_MODE, 8'h05, "mode after wake");
		rdc(`OFS_IDLE_SLEEP, 8'h02, "kept in soft");
		$display("test soft down done");
		// chip power-down pin
		wr(`OFS_PORT_TWO_PWR, 8'h5c);
		chip_power_down_n <= 1'b0;
		wait_state(ST_HW_PD, 8, "pin down");
		ens(9'h1c0, 9'h000, "pin enables");
		@(posedge core_clk) chip_power_down_n <= 1'b1;
		wait_state(ST_NORMAL, 8, "pin release");
		ens(9'h00f, 9'h005, "port two down");
		rdc(`OFS_PORT_TWO_PWR, 8'h5c, "kept over pin");
		$display("test pin done");
		final_report();
	end
endmodule
`default_nettype wire
